//--- shared/mrc_cfg.svh
// Offsets, field positions, reset values and widths of the mode and regulator control bank.
// Assumes the host link decoder delivers 24-bit words whose fields sit in bits 23..8.
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH

`define MRC_ADDR_W 7
`define MRC_DATA_W 24

// Register addresses on the decoded host link
`define MRC_ADDR_MODE 7'h04
`define MRC_ADDR_REGCTL 7'h05
`define MRC_ADDR_ERRFLAG 7'h06

// Operating mode control fields
`define MRC_MODE_PLL_LOCK 16
`define MRC_MODE_EXT_SEL 15
`define MRC_MODE_EXT_DIS 14
`define MRC_MODE_NORMAL 13
`define MRC_MODE_WAKE_INPUT_TWO_BLK 10
`define MRC_MODE_WAKE_INPUT_ONE_BLK 9
`define MRC_MODE_STBY 8

// Regulator on/off control fields
`define MRC_REG_PD_OFF 23
`define MRC_REG_PRE_OFF 22
`define MRC_REG_CORE_OFF 20
`define MRC_REG_SEC_OFF 18
`define MRC_REG_LIN_OFF 17
`define MRC_REG_PRE_ON 14
`define MRC_REG_CORE_ON 12
`define MRC_REG_SEC_ON 10
`define MRC_REG_LIN_ON 9

// Error flag register field
`define MRC_ERR_REQ 8

// Reset values of stored and live fields
`define MRC_RST_NORMAL 1'b1
`define MRC_RST_BIT 1'b0
`define MRC_RST_WORD 24'h000000

`define MRC_NUM_REGULATORS 4

`endif

//--- shared/mrc_pkg.sv
// Types shared by the mode and regulator control bank.
// Assumes mrc_cfg.svh supplies the widths.
`include "mrc_cfg.svh"

package mrc_pkg;

    typedef logic [`MRC_DATA_W-1:0] mrc_word_t;
    typedef logic [`MRC_ADDR_W-1:0] mrc_addr_t;

    // Order of regulators on the on/off pulse vectors
    typedef enum logic [1:0] {
        MRC_PRE_REGULATOR,
        MRC_CORE_BUCK,
        MRC_SECOND_BUCK,
        MRC_LINEAR_REGULATOR
    } mrc_regulator_t;

endpackage : mrc_pkg

//--- verilog/mrc_regs.sv
// Mode and regulator control register bank behind the decoded host link.
// Assumes a link decoder on ref_clk presenting one-cycle read and write strobes,
// live PLL and clock-select levels from an analog domain, and a same-clock state machine.
`timescale 1ns/100ps
`include "mrc_cfg.svh"

module mrc_regs #(
    parameter int unsigned SYNC_STAGES = 3
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire mrc_pkg::mrc_addr_t reg_addr, // Decoded register address
    input wire logic reg_wr, // One-cycle write strobe
    input wire logic reg_rd, // One-cycle read strobe
    input wire mrc_pkg::mrc_word_t reg_wdata, // Write data, fields in 23..8
    input wire logic pll_locked_in, // PLL lock level, asynchronous
    input wire logic ext_ref_selected_in, // External reference in use, asynchronous
    input wire logic main_normal_in, // Main state machine in Normal, same clock
    output logic [`MRC_DATA_W-1:0] reg_rdata, // Read data
    output logic reg_rd_valid, // Read data valid pulse
    output logic access_error, // Sticky invalid-access flag
    output logic wake_two_block, // Block wake from second wake input
    output logic wake_one_block, // Block wake from first wake input
    output logic prereg_pulldown_off, // Force pre-regulator pull-down off
    output logic ext_ref_disable_req, // Pulse: drop external reference
    output logic standby_request, // Pulse: enter Standby
    output logic [`MRC_NUM_REGULATORS-1:0] regulator_off_req, // Pulses per regulator
    output logic [`MRC_NUM_REGULATORS-1:0] regulator_on_req // Pulses per regulator
);

    localparam int unsigned NREG = `MRC_NUM_REGULATORS;
    // Bit positions indexed by mrc_pkg::mrc_regulator_t
    localparam int unsigned OFF_POS [NREG] = '{`MRC_REG_PRE_OFF, `MRC_REG_CORE_OFF,
                                              `MRC_REG_SEC_OFF, `MRC_REG_LIN_OFF};
    localparam int unsigned ON_POS [NREG] = '{`MRC_REG_PRE_ON, `MRC_REG_CORE_ON,
                                             `MRC_REG_SEC_ON, `MRC_REG_LIN_ON};

    // Live input synchronisers
    logic [SYNC_STAGES-1:0] pll_sync_reg;
    logic [SYNC_STAGES-1:0] pll_sync_next;
    logic [SYNC_STAGES-1:0] sel_sync_reg;
    logic [SYNC_STAGES-1:0] sel_sync_next;
    logic pll_live_reg;
    logic pll_live_next;
    logic sel_live_reg;
    logic sel_live_next;
    logic normal_reg;
    logic normal_next;

    // Decode
    logic hit_mode;
    logic hit_regctl;
    logic hit_err;
    logic hit_any;
    logic wr_mode;
    logic wr_regctl;
    logic bad_access;

    // Stored fields and outputs
    logic wake_input_two_reg;
    logic wake_input_two_next;
    logic wake_input_one_reg;
    logic wake_input_one_next;
    logic pd_off_reg;
    logic pd_off_next;
    logic err_reg;
    logic err_next;
    logic ext_dis_reg;
    logic ext_dis_next;
    logic stby_reg;
    logic stby_next;
    logic [NREG-1:0] off_reg;
    logic [NREG-1:0] off_next;
    logic [NREG-1:0] on_reg;
    logic [NREG-1:0] on_next;
    logic [NREG-1:0] on_allowed;
    logic pre_off_seen_reg;
    logic pre_off_seen_next;
    logic [`MRC_DATA_W-1:0] rdata_reg;
    logic [`MRC_DATA_W-1:0] rdata_next;
    logic rd_valid_reg;
    logic rd_valid_next;

    assign hit_mode = (reg_addr == `MRC_ADDR_MODE);
    assign hit_regctl = (reg_addr == `MRC_ADDR_REGCTL);
    assign hit_err = (reg_addr == `MRC_ADDR_ERRFLAG);
    assign hit_any = hit_mode | hit_regctl | hit_err;
    // Both strobes at once, or any strobe to an unmapped address
    assign bad_access = (reg_wr & reg_rd) | ((reg_wr | reg_rd) & ~hit_any);
    assign wr_mode = reg_wr & ~reg_rd & hit_mode;
    assign wr_regctl = reg_wr & ~reg_rd & hit_regctl;

    // Live PLL and clock-select status: a change is taken only once the last two stages agree,
    // so a single metastable sample never reaches the read path.
    always_comb
    begin
        pll_sync_next = {pll_sync_reg[SYNC_STAGES-2:0], pll_locked_in};
        sel_sync_next = {sel_sync_reg[SYNC_STAGES-2:0], ext_ref_selected_in};
        pll_live_next = pll_live_reg;
        sel_live_next = sel_live_reg;
        if (pll_sync_reg[SYNC_STAGES-1] == pll_sync_reg[SYNC_STAGES-2])
        begin
            pll_live_next = pll_sync_reg[SYNC_STAGES-1];
        end
        if (sel_sync_reg[SYNC_STAGES-1] == sel_sync_reg[SYNC_STAGES-2])
        begin
            sel_live_next = sel_sync_reg[SYNC_STAGES-1];
        end
        normal_next = main_normal_in;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pll_sync_reg <= '0;
            sel_sync_reg <= '0;
            pll_live_reg <= `MRC_RST_BIT;
            sel_live_reg <= `MRC_RST_BIT;
            normal_reg <= `MRC_RST_NORMAL;
        end
        else
        begin
            pll_sync_reg <= pll_sync_next;
            sel_sync_reg <= sel_sync_next;
            pll_live_reg <= pll_live_next;
            sel_live_reg <= sel_live_next;
            normal_reg <= normal_next;
        end
    end

    // Stored control fields, request pulses and the error flag
    always_comb
    begin
        wake_input_two_next = wake_input_two_reg;
        wake_input_one_next = wake_input_one_reg;
        pd_off_next = pd_off_reg;
        ext_dis_next = 1'b0;
        stby_next = 1'b0;
        if (wr_mode)
        begin
            wake_input_two_next = reg_wdata[`MRC_MODE_WAKE_INPUT_TWO_BLK];
            wake_input_one_next = reg_wdata[`MRC_MODE_WAKE_INPUT_ONE_BLK];
            ext_dis_next = reg_wdata[`MRC_MODE_EXT_DIS];
            stby_next = reg_wdata[`MRC_MODE_STBY];
        end
        if (wr_regctl)
        begin
            pd_off_next = reg_wdata[`MRC_REG_PD_OFF];
        end
        err_next = err_reg;
        if (reg_wr & ~reg_rd & hit_err & reg_wdata[`MRC_ERR_REQ])
        begin
            err_next = 1'b0;
        end
        // A new fault in the clearing cycle keeps the flag set
        if (bad_access)
        begin
            err_next = 1'b1;
        end
    end

    // Pre-regulator sits at index 0; its on request needs an earlier off
    assign on_allowed = {{(NREG-1){1'b1}}, pre_off_seen_reg};

    // Zero bits leave the regulator as it is; off wins over on.
    generate
        for (genvar g = 0; g < NREG; g++)
        begin : g_reg
            always_comb
            begin
                off_next[g] = wr_regctl & reg_wdata[OFF_POS[g]];
                on_next[g] = wr_regctl & reg_wdata[ON_POS[g]] & on_allowed[g]
                             & ~reg_wdata[OFF_POS[g]];
            end

            always_ff @(posedge ref_clk)
            begin
                if (!rst_n)
                begin
                    off_reg[g] <= 1'b0;
                    on_reg[g] <= 1'b0;
                end
                else
                begin
                    off_reg[g] <= off_next[g];
                    on_reg[g] <= on_next[g];
                end
            end
        end
    endgenerate

    // A pre-regulator back-on request with no off before it is dropped: the rail is already up
    always_comb
    begin
        pre_off_seen_next = pre_off_seen_reg;
        if (on_next[mrc_pkg::MRC_PRE_REGULATOR])
        begin
            pre_off_seen_next = 1'b0;
        end
        if (off_next[mrc_pkg::MRC_PRE_REGULATOR])
        begin
            pre_off_seen_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pre_off_seen_reg <= `MRC_RST_BIT;
        end
        else
        begin
            pre_off_seen_reg <= pre_off_seen_next;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wake_input_two_reg <= `MRC_RST_BIT;
            wake_input_one_reg <= `MRC_RST_BIT;
            pd_off_reg <= `MRC_RST_BIT;
            err_reg <= `MRC_RST_BIT;
            ext_dis_reg <= 1'b0;
            stby_reg <= 1'b0;
        end
        else
        begin
            wake_input_two_reg <= wake_input_two_next;
            wake_input_one_reg <= wake_input_one_next;
            pd_off_reg <= pd_off_next;
            err_reg <= err_next;
            ext_dis_reg <= ext_dis_next;
            stby_reg <= stby_next;
        end
    end

    // Read path: request and reserved positions always return 0
    always_comb
    begin
        rdata_next = `MRC_RST_WORD;
        rd_valid_next = 1'b0;
        if (reg_rd & ~reg_wr & hit_any)
        begin
            rd_valid_next = 1'b1;
            if (hit_mode)
            begin
                rdata_next[`MRC_MODE_PLL_LOCK] = pll_live_reg;
                rdata_next[`MRC_MODE_EXT_SEL] = sel_live_reg;
                rdata_next[`MRC_MODE_NORMAL] = normal_reg;
                rdata_next[`MRC_MODE_WAKE_INPUT_TWO_BLK] = wake_input_two_reg;
                rdata_next[`MRC_MODE_WAKE_INPUT_ONE_BLK] = wake_input_one_reg;
            end
            else if (hit_regctl)
            begin
                rdata_next[`MRC_REG_PD_OFF] = pd_off_reg;
            end
            else
            begin
                rdata_next[`MRC_ERR_REQ] = err_reg;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rdata_reg <= `MRC_RST_WORD;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rd_valid = rd_valid_reg;
    assign access_error = err_reg;
    assign wake_two_block = wake_input_two_reg;
    assign wake_one_block = wake_input_one_reg;
    assign prereg_pulldown_off = pd_off_reg;
    assign ext_ref_disable_req = ext_dis_reg;
    assign standby_request = stby_reg;
    assign regulator_off_req = off_reg;
    assign regulator_on_req = on_reg;

endmodule : mrc_regs

//--- test/mrc_regs_checker.sv
// Assertions on the link answers and request outputs of the register bank.
// Assumes binding to mrc_regs; all inputs are sampled on ref_clk.
`timescale 1ns/100ps
`include "mrc_cfg.svh"
module mrc_regs_checker (
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire mrc_pkg::mrc_addr_t reg_addr, // Address
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire mrc_pkg::mrc_word_t reg_wdata, // Write data
    input wire logic [`MRC_DATA_W-1:0] reg_rdata, // Read data
    input wire logic reg_rd_valid, // Read valid
    input wire logic access_error, // Error flag
    input wire logic prereg_pulldown_off, // Pull-down off
    input wire logic standby_request, // Standby pulse
    input wire logic [`MRC_NUM_REGULATORS-1:0] regulator_off_req, // Off pulses
    input wire logic [`MRC_NUM_REGULATORS-1:0] regulator_on_req // On pulses
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire wr_ok = reg_wr && !reg_rd;
    wire wr_mode = wr_ok && reg_addr == `MRC_ADDR_MODE;
    wire wr_reg = wr_ok && reg_addr == `MRC_ADDR_REGCTL;
    wire clr = wr_ok && reg_addr == `MRC_ADDR_ERRFLAG && reg_wdata[8];
    property p_rd;
        reg_rd && !reg_wr && reg_addr == `MRC_ADDR_MODE |=>
            reg_rd_valid && reg_rdata[23:17] == 7'h00 && reg_rdata[12:11] == 2'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("mode read bad");
    property p_bad;
        reg_wr && reg_rd |=> access_error && !reg_rd_valid;
    endproperty
    a_bad: assert property (p_bad) else $error("bad access kept");
    property p_stk;
        access_error && !clr |=> access_error;
    endproperty
    a_stk: assert property (p_stk) else $error("error flag lost");
    property p_stb;
        wr_mode |=> standby_request == $past(reg_wdata[8]);
    endproperty
    a_stb: assert property (p_stb) else $error("standby pulse wrong");
    property p_pd;
        wr_reg |=> prereg_pulldown_off == $past(reg_wdata[23]);
    endproperty
    a_pd: assert property (p_pd) else $error("pull-down bit wrong");
    property p_win;
        wr_reg && reg_wdata[22] |=> regulator_off_req[0] && !regulator_on_req[0];
    endproperty
    a_win: assert property (p_win) else $error("off not winning");
    property p_core;
        wr_reg |=> regulator_on_req[1] == ($past(reg_wdata[12]) && !$past(reg_wdata[20]));
    endproperty
    a_core: assert property (p_core) else $error("core on pulse wrong");
    property p_quiet;
        !wr_reg |=> regulator_off_req == 4'h0 && regulator_on_req == 4'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("stray request");
endmodule : mrc_regs_checker

//--- test/mrc_host.sv
// Host model driving the decoded register link of the bank.
// Assumes the bench calls xfer; released lines are scrambled, not held.
`timescale 1ns/100ps
module mrc_host (
    input wire logic ref_clk, // Clock
    output mrc_pkg::mrc_addr_t reg_addr = 7'h00, // Address
    output logic reg_wr = 1'b0, // Write strobe
    output logic reg_rd = 1'b0, // Read strobe
    output mrc_pkg::mrc_word_t reg_wdata = 24'h000000 // Write data
);
    task automatic xfer(input logic w, input logic r, input logic [6:0] a, input logic [23:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : xfer
endmodule : mrc_host

//--- test/mrc_regs_test.sv
// Self-checking bench of the mode and regulator control bank.
// Assumes mrc_host drives the link; outputs are read 1 ns after the answer edge.
`timescale 1ns/100ps
module mrc_regs_test;
    typedef struct packed
    {
        logic [6:0] a;
        logic [23:0] d;
        logic [23:0] r;
        logic [1:0] p;
        logic [3:0] off;
        logic [3:0] on;
    } mrc_row_t;
    mrc_row_t rows [8] = '{
        '{7'h04, 24'h000600, 24'h002600, 2'h0, 4'h0, 4'h0},
        '{7'h04, 24'h000400, 24'h002400, 2'h0, 4'h0, 4'h0},
        '{7'h04, 24'h004100, 24'h002000, 2'h3, 4'h0, 4'h0},
        '{7'h05, 24'h800000, 24'h800000, 2'h0, 4'h0, 4'h0},
        '{7'h05, 24'h565600, 24'h000000, 2'h0, 4'hf, 4'h0},
        '{7'h05, 24'h005600, 24'h000000, 2'h0, 4'h0, 4'hf},
        '{7'h05, 24'h900400, 24'h800000, 2'h0, 4'h2, 4'h4},
        '{7'h05, 24'h804000, 24'h800000, 2'h0, 4'h0, 4'h0}};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pll_locked_in = 1'b0;
    logic ext_ref_selected_in = 1'b0;
    logic main_normal_in = 1'b1;
    mrc_pkg::mrc_addr_t reg_addr;
    mrc_pkg::mrc_word_t reg_wdata;
    mrc_pkg::mrc_word_t reg_rdata;
    logic reg_wr, reg_rd, reg_rd_valid, access_error, wake_two_block, wake_one_block;
    logic prereg_pulldown_off, ext_ref_disable_req, standby_request;
    logic [3:0] regulator_off_req, regulator_on_req;
    wire [23:0] mode_seen = {22'h0, ext_ref_disable_req, standby_request};
    wire [23:0] off_seen = {20'h0, regulator_off_req};
    wire [23:0] on_seen = {20'h0, regulator_on_req};
    wire [23:0] lvl_seen = {21'h0, prereg_pulldown_off, wake_two_block, wake_one_block};
    int err_count = 0;
    int total_checks = 0;
    initial forever #5 ref_clk = ~ref_clk;
    mrc_regs mrc_regs_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .pll_locked_in(pll_locked_in),
        .ext_ref_selected_in(ext_ref_selected_in),
        .main_normal_in(main_normal_in),
        .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid),
        .access_error(access_error),
        .wake_two_block(wake_two_block),
        .wake_one_block(wake_one_block),
        .prereg_pulldown_off(prereg_pulldown_off),
        .ext_ref_disable_req(ext_ref_disable_req),
        .standby_request(standby_request),
        .regulator_off_req(regulator_off_req),
        .regulator_on_req(regulator_on_req)
    );
    mrc_host mrc_host_i (
        .ref_clk(ref_clk),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata)
    );
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd_chk(input logic [6:0] a, input logic [23:0] e);
        mrc_host_i.xfer(1'b0, 1'b1, a, 24'h000000);
        chk("read valid", 24'h000001, {23'h0, reg_rd_valid});
        chk("read data", e, reg_rdata);
    endtask : rd_chk
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (10) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        rd_chk(7'h04, 24'h002000);
        rd_chk(7'h05, 24'h000000);
        foreach (rows[i])
        begin
            mrc_host_i.xfer(1'b1, 1'b0, rows[i].a, rows[i].d);
            chk("mode pulses", {22'h0, rows[i].p}, mode_seen);
            chk("off reqs", {20'h0, rows[i].off}, off_seen);
            chk("on reqs", {20'h0, rows[i].on}, on_seen);
            chk("levels", {21'h0, rows[i].r[23], rows[i].r[10:9]}, lvl_seen);
            rd_chk(rows[i].a, rows[i].r);
        end
        pll_locked_in = 1'b1;
        ext_ref_selected_in = 1'b1;
        main_normal_in = 1'b0;
        // Synchroniser plus live flop needs 4 cycles
        repeat (5) @(posedge ref_clk);
        rd_chk(7'h04, 24'h018000);
        mrc_host_i.xfer(1'b1, 1'b1, 7'h04, 24'h000600);
        chk("both strobes", 24'h000001, {23'h0, access_error});
        mrc_host_i.xfer(1'b0, 1'b1, 7'h7f, 24'h000000);
        chk("unmapped valid", 24'h000000, {23'h0, reg_rd_valid});
        rd_chk(7'h04, 24'h018000);
        rd_chk(7'h06, 24'h000100);
        mrc_host_i.xfer(1'b1, 1'b0, 7'h06, 24'h000100);
        chk("error clear", 24'h000000, {23'h0, access_error});
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        rd_chk(7'h05, 24'h000000);
        wrap_up();
    end
endmodule : mrc_regs_test
bind mrc_regs mrc_regs_checker mrc_regs_checker_i (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid),
    .access_error(access_error),
    .prereg_pulldown_off(prereg_pulldown_off),
    .standby_request(standby_request),
    .regulator_off_req(regulator_off_req),
    .regulator_on_req(regulator_on_req)
);
